//--- include/alc_consts.svh
// Constants of the ambient light level comparator: offsets, resets, scales
`ifndef ALC_CONSTS_SVH
`define ALC_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ALC_OFFS_OFFICE_THR 8'h1d
`define ALC_OFFS_OFFICE_HYS 8'h1e
`define ALC_OFFS_DARK_THR 8'h1f
`define ALC_OFFS_DARK_HYS 8'h20

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ALC_RST_OFFICE_THR 8'h00
`define ALC_RST_OFFICE_HYS 8'h00
`define ALC_RST_DARK_THR 8'h00
`define ALC_RST_DARK_HYS 8'h00

// ----------------------------------------------------------------
// Current scales, in nanoamperes per code step
// ----------------------------------------------------------------
`define ALC_OFFICE_STEP_NA 23'h0010cc
`define ALC_DARK_STEP_NA 23'h00021c
`define ALC_SENSOR_STEP_NA 23'h000087

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ALC_CLK_KHZ 20000
`define ALC_REFRESH_MS 80

`endif

//--- include/alc_pkg.sv
// Types shared by the ambient light level comparator
package alc_pkg;

    // Backlight brightness level selected from ambient light
    typedef enum logic [1:0] {
        ALC_LVL_DAYLIGHT,
        ALC_LVL_OFFICE,
        ALC_LVL_DARK
    } alc_level_e;

    // Sensor enable that gates the refresh, and comparator enables that steer the level choice
    typedef struct packed {
        logic sensor_en;
        logic office_en;
        logic dark_en;
    } alc_ctrl_s;

    // Comparator results and selected level
    typedef struct packed {
        logic office_out;
        logic dark_out;
        alc_level_e level;
    } alc_status_s;

endpackage : alc_pkg

//--- design/alc_comparator.sv
// Ambient light level comparator with hysteresis and register file
`timescale 1ns/1ps
`default_nettype none
`include "alc_consts.svh"

module alc_comparator #(
    parameter int REFRESH_CYCLES = `ALC_REFRESH_MS * `ALC_CLK_KHZ
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic [12:0] i_light_sensor_input,
    input wire alc_pkg::alc_ctrl_s i_ctrl,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic [12:0] o_conv_value,
    output logic o_conv_update,
    output alc_pkg::alc_status_s o_status
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] office_threshold_reg;
    logic [7:0] office_hysteresis_reg;
    logic [7:0] dark_threshold_reg;
    logic [7:0] dark_hysteresis_reg;
    logic [12:0] sensor_meta_reg;
    logic [12:0] sensor_sync_reg;
    logic [12:0] sensor_prev_reg;
    logic [12:0] sensor_settled_reg;
    logic [20:0] tick_cnt_reg;
    logic tick;
    logic office_state_reg;
    logic dark_state_reg;
    logic office_state_next;
    logic dark_state_next;
    logic [22:0] sensor_na;
    logic [22:0] office_lo_na;
    logic [22:0] office_hi_na;
    logic [22:0] dark_lo_na;
    logic [22:0] dark_hi_na;
    alc_pkg::alc_level_e level_next;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------

    // Writes at the printed offsets; other offsets are ignored
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            office_threshold_reg <= `ALC_RST_OFFICE_THR;
            office_hysteresis_reg <= `ALC_RST_OFFICE_HYS;
            dark_threshold_reg <= `ALC_RST_DARK_THR;
            dark_hysteresis_reg <= `ALC_RST_DARK_HYS;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                `ALC_OFFS_OFFICE_THR: office_threshold_reg <= i_reg_wdata;
                `ALC_OFFS_OFFICE_HYS: office_hysteresis_reg <= i_reg_wdata;
                `ALC_OFFS_DARK_THR: dark_threshold_reg <= i_reg_wdata;
                `ALC_OFFS_DARK_HYS: dark_hysteresis_reg <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    // Registered read data, one cycle after the address; unmapped reads 0
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_reg_rdata <= 8'h00;
        end else begin
            case (i_reg_addr)
                `ALC_OFFS_OFFICE_THR: o_reg_rdata <= office_threshold_reg;
                `ALC_OFFS_OFFICE_HYS: o_reg_rdata <= office_hysteresis_reg;
                `ALC_OFFS_DARK_THR: o_reg_rdata <= dark_threshold_reg;
                `ALC_OFFS_DARK_HYS: o_reg_rdata <= dark_hysteresis_reg;
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sensor input capture
    // ------------------------------------------------------------

    // Two-stage synchroniser on every bit of the converter bus
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            sensor_meta_reg <= 13'h0000;
            sensor_sync_reg <= 13'h0000;
        end else begin
            sensor_meta_reg <= i_light_sensor_input;
            sensor_sync_reg <= sensor_meta_reg;
        end
    end

    // A word is trusted only once two synced samples agree: bits of a
    // changing bus may resolve in different cycles; costs one cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            sensor_prev_reg <= 13'h0000;
            sensor_settled_reg <= 13'h0000;
        end else begin
            sensor_prev_reg <= sensor_sync_reg;
            if (sensor_sync_reg == sensor_prev_reg) begin
                sensor_settled_reg <= sensor_sync_reg;
            end
        end
    end

    // Refresh timebase, held at zero while the sensor is off
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || !i_ctrl.sensor_en) begin
            tick_cnt_reg <= 21'h000000;
        end else if (tick) begin
            tick_cnt_reg <= 21'h000000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 21'h000001;
        end
    end

    assign tick = i_ctrl.sensor_en
        && (tick_cnt_reg == 21'(REFRESH_CYCLES - 1));

    // Latch the conversion value the comparators evaluate
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_conv_value <= 13'h0000;
            o_conv_update <= 1'b0;
        end else begin
            o_conv_update <= tick;
            if (tick) begin
                o_conv_value <= sensor_settled_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Comparison in nanoamperes
    // ------------------------------------------------------------

    // Sums are widened to nine bits, so codes past the software limit
    // still compare as a larger current instead of wrapping around
    // Common current scale so the two code steps compare fairly
    always_comb begin
        sensor_na = 23'(o_conv_value) * `ALC_SENSOR_STEP_NA;
        office_lo_na = 23'(office_threshold_reg) * `ALC_OFFICE_STEP_NA;
        office_hi_na = 23'({1'b0, office_threshold_reg}
            + {1'b0, office_hysteresis_reg}) * `ALC_OFFICE_STEP_NA;
        dark_lo_na = 23'(dark_threshold_reg) * `ALC_DARK_STEP_NA;
        dark_hi_na = 23'({1'b0, dark_threshold_reg}
            + {1'b0, dark_hysteresis_reg}) * `ALC_DARK_STEP_NA;
    end

    // Hysteretic trip states; inside the band the state holds
    always_comb begin
        office_state_next = office_state_reg;
        dark_state_next = dark_state_reg;
        if (sensor_na < office_lo_na) begin
            office_state_next = 1'b1;
        end else if (sensor_na > office_hi_na) begin
            office_state_next = 1'b0;
        end
        if (sensor_na < dark_lo_na) begin
            dark_state_next = 1'b1;
        end else if (sensor_na > dark_hi_na) begin
            dark_state_next = 1'b0;
        end
    end

    // Level choice; dark wins whenever its comparator is enabled and tripped
    always_comb begin
        if (i_ctrl.dark_en && dark_state_next) begin
            level_next = alc_pkg::ALC_LVL_DARK;
        end else if (i_ctrl.office_en) begin
            level_next = office_state_next ? alc_pkg::ALC_LVL_OFFICE
                : alc_pkg::ALC_LVL_DAYLIGHT;
        end else if (i_ctrl.dark_en) begin
            level_next = alc_pkg::ALC_LVL_OFFICE;
        end else begin
            level_next = alc_pkg::ALC_LVL_DAYLIGHT;
        end
    end

    // ------------------------------------------------------------
    // State update on each refresh
    // ------------------------------------------------------------

    // Comparators evaluate one cycle after the value is latched
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            office_state_reg <= 1'b0;
            dark_state_reg <= 1'b0;
            o_status <= '{office_out: 1'b0, dark_out: 1'b0,
                level: alc_pkg::ALC_LVL_DAYLIGHT};
        end else if (o_conv_update) begin
            office_state_reg <= office_state_next;
            dark_state_reg <= dark_state_next;
            o_status.office_out <= office_state_next;
            o_status.dark_out <= dark_state_next;
            o_status.level <= level_next;
        end
    end

endmodule : alc_comparator

`default_nettype wire

//--- testbench/alc_comparator_monitor.sv
// Port checker for the ambient light level comparator
`timescale 1ns/1ps
`default_nettype none
module alc_comparator_monitor #(
    parameter int REFRESH_CYCLES = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic [12:0] i_light_sensor_input,
    input wire alc_pkg::alc_ctrl_s i_ctrl,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [12:0] o_conv_value,
    input wire logic o_conv_update,
    input wire alc_pkg::alc_status_s o_status
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    int gap;
    logic en_ok;
    // Cycles since last refresh; 0 means none seen yet, so no false period
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) gap <= 0;
        else if (o_conv_update) gap <= 1;
        else if (gap != 0) gap <= gap + 1;
    end
    // Period only judged when the sensor stayed enabled all the way
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || o_conv_update) en_ok <= 1'b1;
        else en_ok <= en_ok & i_ctrl.sensor_en;
    end
    property p_pulse; o_conv_update |=> !o_conv_update; endproperty
    a_pulse: assert property (p_pulse) else $error("long pulse");
    property p_value; $changed(o_conv_value) |-> o_conv_update; endproperty
    a_value: assert property (p_value) else $error("stray value");
    property p_period;
        o_conv_update && gap != 0 && en_ok |-> gap == REFRESH_CYCLES;
    endproperty
    a_period: assert property (p_period) else $error("period");
    property p_hold; $changed(o_status) |-> $past(o_conv_update); endproperty
    a_hold: assert property (p_hold) else $error("stray level");
    property p_dark;
        $past(o_conv_update) && $stable(i_ctrl) && i_ctrl.dark_en
        && o_status.dark_out |-> o_status.level == alc_pkg::ALC_LVL_DARK;
    endproperty
    a_dark: assert property (p_dark) else $error("dark lost");
    property p_office;
        $past(o_conv_update) && $stable(i_ctrl) && i_ctrl.office_en
        && !(i_ctrl.dark_en && o_status.dark_out) |-> o_status.level ==
        (o_status.office_out ? alc_pkg::ALC_LVL_OFFICE
        : alc_pkg::ALC_LVL_DAYLIGHT);
    endproperty
    a_office: assert property (p_office) else $error("office");
    property p_dkonly;
        $past(o_conv_update) && $stable(i_ctrl) && !i_ctrl.office_en
        && i_ctrl.dark_en && !o_status.dark_out
        |-> o_status.level == alc_pkg::ALC_LVL_OFFICE;
    endproperty
    a_dkonly: assert property (p_dkonly) else $error("dark exit");
    property p_wr;
        i_reg_wr && i_reg_addr inside {[8'h1d:8'h20]} ##1 $stable(i_reg_addr)
        && !i_reg_wr |=> o_reg_rdata == $past(i_reg_wdata, 2);
    endproperty
    a_wr: assert property (p_wr) else $error("readback");
endmodule : alc_comparator_monitor
bind alc_comparator alc_comparator_monitor #(
    .REFRESH_CYCLES(REFRESH_CYCLES)
) alc_comparator_monitor_i (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_ctrl(i_ctrl),
    .i_light_sensor_input(i_light_sensor_input), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_conv_value(o_conv_value),
    .o_conv_update(o_conv_update), .o_status(o_status)
);
`default_nettype wire

//--- testbench/alc_sensor_model.sv
// Photosensor front end model driving the converter result
`timescale 1ns/1ps
`default_nettype none
module alc_sensor_model (
    input wire logic i_clk_sys,
    input wire logic [12:0] i_target,
    output logic [12:0] o_light_sensor_input = 13'h0000
);
    // Moves a few ns after the edge: the block must resync it
    always @(posedge i_clk_sys) begin
        o_light_sensor_input <= #3 i_target;
    end
endmodule : alc_sensor_model
`default_nettype wire

//--- testbench/alc_comparator_bench.sv
// Self-checking bench for the ambient light level comparator
`timescale 1ns/1ps
`default_nettype none
module alc_comparator_bench;
    localparam int REFRESH = 16;
    logic i_clk_sys = 1'b0;
    logic i_srst = 1'b1;
    logic wr = 1'b0;
    logic upd;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [7:0] regv [4];
    logic [12:0] sensor, conv, target = 13'h0000;
    alc_pkg::alc_ctrl_s ctrl = 3'h0;
    alc_pkg::alc_status_s status;
    alc_pkg::alc_level_e lvl;
    logic otrip = 1'b0, dtrip = 1'b0;
    int num_errors = 0, samples_checked = 0;
    always #25 i_clk_sys = ~i_clk_sys;
    alc_sensor_model alc_sensor_model_i (.i_clk_sys(i_clk_sys),
        .i_target(target), .o_light_sensor_input(sensor));
    alc_comparator #(.REFRESH_CYCLES(REFRESH)) alc_comparator_i (
        .i_clk_sys(i_clk_sys), .i_srst(i_srst),
        .i_light_sensor_input(sensor), .i_ctrl(ctrl),
        .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_conv_value(conv),
        .o_conv_update(upd), .o_status(status));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic step;
        @(posedge i_clk_sys);
        #1;
    endtask : step
    task automatic chk(input string nm, input logic [12:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Every write is followed by a read, so wr never rises twice in a step
    task automatic wreg(input logic [7:0] a, d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        step;
        wr = 1'b0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, exp);
        addr = a;
        step;
        chk("rdata", {5'h00, rdata}, {5'h00, exp});
    endtask : rreg
    // Trip states hold inside the band; only refreshes move them
    function automatic alc_pkg::alc_level_e exp_lvl(input logic [12:0] v);
        int na = v * 135;
        if (na < regv[0] * 4300) otrip = 1'b1;
        else if (na > (regv[0] + regv[1]) * 4300) otrip = 1'b0;
        if (na < regv[2] * 540) dtrip = 1'b1;
        else if (na > (regv[2] + regv[3]) * 540) dtrip = 1'b0;
        if (ctrl.dark_en && dtrip) return alc_pkg::ALC_LVL_DARK;
        if (ctrl.office_en) return otrip ? alc_pkg::ALC_LVL_OFFICE
            : alc_pkg::ALC_LVL_DAYLIGHT;
        return ctrl.dark_en ? alc_pkg::ALC_LVL_OFFICE
            : alc_pkg::ALC_LVL_DAYLIGHT;
    endfunction : exp_lvl
    task automatic results;
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(95));
        repeat (3) step;
        i_srst = 1'b0;
        regv[0] = 8'($urandom_range(10, 200));
        regv[1] = 8'($urandom_range(0, 250 - regv[0]));
        regv[2] = 8'($urandom);
        regv[3] = 8'($urandom);
        for (int i = 0; i < 4; i++) begin
            wreg(8'(8'h1d + i), regv[i]);
            rreg(8'(8'h1d + i), regv[i]);
        end
        rreg(8'h21, 8'h00);
        $display("test registers done");
        for (int k = 0; k < 30; k++) begin
            if (k % 7 == 6) begin
                ctrl.sensor_en = 1'b0;
                repeat (3 * REFRESH) begin
                    step;
                    chk("update", {12'h000, upd}, 13'h0000);
                end
            end
            case ($urandom_range(0, 4))
                0: target = 13'(regv[0] * 4300 / 135);
                1: target = 13'((regv[0] + regv[1]) * 4300 / 135 + 1);
                2: target = 13'(regv[2] * 4);
                3: target = 13'((regv[2] + regv[3]) * 4 + 1);
                default: target = 13'($urandom_range(0, 8191));
            endcase
            ctrl = alc_pkg::alc_ctrl_s'({1'b1, 2'($urandom)});
            for (int n = 0; n < 4 * REFRESH && upd !== 1'b1; n++) step;
            chk("update", {12'h000, upd}, 13'h0001);
            chk("conv", conv, target);
            lvl = exp_lvl(target);
            step;
            chk("office", 13'(status.office_out), 13'(otrip));
            chk("dark", 13'(status.dark_out), 13'(dtrip));
            chk("level", 13'(status.level), 13'(lvl));
        end
        $display("test levels done");
        // Mid-run reset must clear registers and outputs again
        i_srst = 1'b1;
        repeat (3) step;
        i_srst = 1'b0;
        step;
        chk("conv_rst", conv, 13'h0000);
        chk("status_rst", {9'h000, status}, 13'h0000);
        for (int i = 0; i < 4; i++) rreg(8'(8'h1d + i), 8'h00);
        $display("test reset done");
        results;
    end
    // Hang guard: far beyond the several hundred cycles the tests need
    initial begin
        #(50 * 20000);
        num_errors++;
        results;
    end
endmodule : alc_comparator_bench
`default_nettype wire
